// ---- gpe_pin_model.sv ----
`timescale 1ns/1ps
module gpe_pin_model (
    input  wire logic       mclk,     // system clock
    input  wire logic [7:0] pinOut,   // pad drive value
    input  wire logic [7:0] pinOe,    // pad drive enable
    input  wire logic [7:0] pullUpEn, // pad pull-up
    input  wire logic [7:0] extEn,    // outside circuit drives
    input  wire logic [7:0] extVal,   // outside circuit level
    output logic      [7:0] pinIn     // resolved pin level
);
    logic [7:0] lastFf = 8'h00;
    // an undriven pin without pull-up shows the inverse of its last level
    always_comb pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal)
        | (~pinOe & ~extEn & (pullUpEn | ~lastFf));
    always @(posedge mclk) lastFf <= pinIn;
endmodule // gpe_pin_model

// ---- gpe_port.v ----
// Function
// - up to eight pins; bit n of each register controls pin n
// - direction zero: pin is input, latch read returns sampled pin level
// - latch write in input mode stores value but leaves pin undriven
// - pad bit in input mode enables pull-up and external interrupt source
// - edge or level sensitivity selected per vector, not per pin
// - up to seven vectors; several pins may share one vector; the 2-bit VEC_OF_PIN index maps pins to vectors 0 to 3 only
// - interrupt pins of one vector are combined; one low pin masks others
// - vector request latch clears when the cpu fetches that vector
// - a write changing a vector's sensitivity clears its pending request
// - request reaches cpu only when pin configured and global mask clear
// - direction one: pin is output, latch drives it, reads return latch
// - output pad bit: one push-pull, zero open-drain floating on high
// - enabled alternate output forces output and overrides port settings
// - input pin with alternate output: latch read returns alternate value
// - output pin with alternate input: peripheral receives latch value
// - wait and halt leave pins alone; enabled interrupts wake the device
// - dir,pad: 00 floating, 01 pull-up irq, 10 open-drain, 11 push-pull
// - sensitivity: fall and low level, rise only, fall only, both edges
// - true open-drain pins: no pull-up, open-drain as port output; alternate output drives both levels
`timescale 1ns/1ps
`include "gpe_regs.vh"
module gpe_port #(
    parameter PINS       = 8,          // pins in the port
    parameter VECS       = 7,          // external interrupt vectors
    parameter [15:0] VEC_OF_PIN = 16'h0000, // 2-bit vector index per pin
    parameter [7:0]  TRUE_OD    = 8'h00     // pins with true open-drain pads
) (
    input  wire            mclk,            // system clock
    input  wire            rst,             // synchronous reset, active high
    input  wire            psel,            // apb select
    input  wire            penable,         // apb enable
    input  wire            pwrite,          // apb direction
    input  wire [11:0]     paddr,           // apb byte address
    input  wire [31:0]     pwdata,          // apb write data
    output reg  [31:0]     prdata,          // apb read data
    output reg             pready,          // apb ready
    output reg             pslverr,         // apb error on unmapped address
    input  wire [PINS-1:0] pinIn,           // sampled pad level
    output reg  [PINS-1:0] pinOut,          // pad output level
    output reg  [PINS-1:0] pinOe,           // pad output enable, high drives
    output reg  [PINS-1:0] pullUpEn,        // pad pull-up enable
    input  wire [PINS-1:0] altOutEn,        // peripheral alternate output enable
    input  wire [PINS-1:0] altOutVal,       // peripheral alternate output value
    output reg  [PINS-1:0] altInVal,        // value presented to peripherals
    input  wire [VECS-1:0] vecFetch,        // cpu fetches vector, one-cycle pulse
    output reg  [VECS-1:0] irqReq,          // gated request per vector
    output reg             wakeUp           // wake from wait or halt
);
    // software-visible port state
    reg  [PINS-1:0]   latch_ff;
    reg  [PINS-1:0]   nxt_latch;
    reg  [PINS-1:0]   dir_ff;
    reg  [PINS-1:0]   nxt_dir;
    reg  [PINS-1:0]   pad_ff;
    reg  [PINS-1:0]   nxt_pad;
    reg  [PINS-1:0]   altEn_ff;
    reg  [PINS-1:0]   nxt_altEn;
    reg  [2:0]        cpu_ff;
    reg  [2:0]        nxt_cpu;
    reg  [2*VECS-1:0] sense_ff;
    reg  [2*VECS-1:0] nxt_sense;

    // interrupt request state
    reg  [VECS-1:0]   pend_ff;
    reg  [VECS-1:0]   comb_ff;

    // read path
    reg  [31:0]       rdMux;
    reg               rdOk;

    wire [VECS-1:0]   comb;
    wire [VECS-1:0]   evtHit;
    wire [VECS-1:0]   senseChg;
    wire [VECS-1:0]   nxt_pend;
    wire [PINS-1:0]   altDrive;
    wire [PINS-1:0]   rdLatch;
    wire [PINS-1:0]   nxt_pinOut;
    wire [PINS-1:0]   nxt_pinOe;
    wire [PINS-1:0]   nxt_pullUp;
    wire [PINS-1:0]   nxt_altIn;
    wire [PINS-1:0]   irqPin;
    wire [PINS-1:0]   effOut;
    wire              setupPh;
    wire              wrEn;
    wire              rdEn;

    // sensitivity event detection on combined vector signal
    function evt;
        input [1:0] sel;
        input       cur;
        input       prev;
        begin
            case (sel)
                `GPE_SENS_FALLLOW: evt = ~cur;
                `GPE_SENS_RISE:    evt = cur & ~prev;
                `GPE_SENS_FALL:    evt = ~cur & prev;
                default:           evt = cur ^ prev;
            endcase
        end
    endfunction

    // address match of one register
    function regHit;
        input [11:0] addr;
        input [11:0] target;
        begin
            regHit = (addr == target);
        end
    endfunction

    // mask of the pins that feed one vector
    function [PINS-1:0] pinsOfVec;
        input integer v;
        integer       p;
        begin
            pinsOfVec = {PINS{1'b0}};
            for (p = 0; p < PINS; p = p + 1) begin
                pinsOfVec[p] = (VEC_OF_PIN[2*p +: 2] == v[1:0]) && (v < 4);
            end
        end
    endfunction

    // apb phase decode; writes land on the access edge with ready high
    assign setupPh = psel & ~penable;
    assign wrEn    = psel & penable & pwrite & pready;
    assign rdEn    = setupPh & ~pwrite;

    // per-pin effective interrupt enable and effective direction
    assign irqPin = ~dir_ff & pad_ff & ~altEn_ff;
    assign effOut = dir_ff | altEn_ff;

    // register write decode
    always @* begin
        nxt_latch = latch_ff;
        nxt_dir   = dir_ff;
        nxt_pad   = pad_ff;
        nxt_altEn = altEn_ff;
        nxt_cpu   = cpu_ff;
        nxt_sense = sense_ff;
        if (wrEn) begin
            if (regHit(paddr, `GPE_ADDR_LATCH)) begin
                // stored even while the pin is an input
                nxt_latch = pwdata[PINS-1:0];
            end
            if (regHit(paddr, `GPE_ADDR_DIR)) begin
                nxt_dir = pwdata[PINS-1:0];
            end
            if (regHit(paddr, `GPE_ADDR_PAD)) begin
                nxt_pad = pwdata[PINS-1:0];
            end
            if (regHit(paddr, `GPE_ADDR_ALTEN)) begin
                nxt_altEn = pwdata[PINS-1:0];
            end
            if (regHit(paddr, `GPE_ADDR_CPU)) begin
                nxt_cpu = pwdata[2:0];
            end
            if (regHit(paddr, `GPE_ADDR_SENSE)) begin
                nxt_sense = pwdata[2*VECS-1:0];
            end
        end
    end

    // per-vector combining, event detection and request latch
    genvar gv;
    generate
        for (gv = 0; gv < VECS; gv = gv + 1) begin : g_vec
            // any enabled pin held low pulls the vector low
            assign comb[gv]     = &(pinIn | ~(irqPin & pinsOfVec(gv)));
            assign evtHit[gv]   = evt(sense_ff[2*gv +: 2], comb[gv], comb_ff[gv]);
            assign senseChg[gv] = nxt_sense[2*gv +: 2] != sense_ff[2*gv +: 2];
            // an event in the clearing cycle wins
            assign nxt_pend[gv] = evtHit[gv] |
                                  (pend_ff[gv] & ~vecFetch[gv] & ~senseChg[gv]);
        end
    endgenerate

    // per-pin drive, pull-up, read-back and peripheral input
    genvar gp;
    generate
        for (gp = 0; gp < PINS; gp = gp + 1) begin : g_pin
            assign altDrive[gp]   = altEn_ff[gp] & altOutEn[gp];
            assign rdLatch[gp]    = altDrive[gp] ? altOutVal[gp] :
                                    dir_ff[gp]   ? latch_ff[gp]  :
                                                   pinIn[gp];
            assign nxt_pinOut[gp] = altDrive[gp] ? altOutVal[gp] :
                                    dir_ff[gp]   ? latch_ff[gp]  : 1'b0;
            // open-drain leaves a high latch floating; input drives only for an active alternate output
            assign nxt_pinOe[gp]  = altDrive[gp] ? 1'b1 :
                                    dir_ff[gp]   ? (~latch_ff[gp] |
                                                    (pad_ff[gp] & ~TRUE_OD[gp])) :
                                                   1'b0;
            assign nxt_pullUp[gp] = ~effOut[gp] & pad_ff[gp] & ~TRUE_OD[gp];
            assign nxt_altIn[gp]  = dir_ff[gp] ? latch_ff[gp] : pinIn[gp];
        end
    endgenerate

    // read mux
    always @* begin
        rdMux = 32'h0000_0000;
        rdOk  = 1'b1;
        case (paddr)
            `GPE_ADDR_LATCH:  rdMux[PINS-1:0]   = rdLatch;
            `GPE_ADDR_DIR:    rdMux[PINS-1:0]   = dir_ff;
            `GPE_ADDR_PAD:    rdMux[PINS-1:0]   = pad_ff;
            `GPE_ADDR_SENSE:  rdMux[2*VECS-1:0] = sense_ff;
            `GPE_ADDR_STATUS: rdMux[VECS-1:0]   = pend_ff;
            `GPE_ADDR_CPU:    rdMux[2:0]        = cpu_ff;
            `GPE_ADDR_ALTEN:  rdMux[PINS-1:0]   = altEn_ff;
            default:          rdOk              = 1'b0;
        endcase
    end

    // register state
    always @(posedge mclk) begin
        if (rst) begin
            latch_ff <= `GPE_RST_BYTE;
            dir_ff   <= `GPE_RST_BYTE;
            pad_ff   <= `GPE_RST_BYTE;
            altEn_ff <= `GPE_RST_BYTE;
            cpu_ff   <= `GPE_CPU_RST;
            sense_ff <= {2*VECS{1'b0}};
            pend_ff  <= {VECS{1'b0}};
            comb_ff  <= {VECS{1'b1}};
        end else begin
            latch_ff <= nxt_latch;
            dir_ff   <= nxt_dir;
            pad_ff   <= nxt_pad;
            altEn_ff <= nxt_altEn;
            cpu_ff   <= nxt_cpu;
            sense_ff <= nxt_sense;
            pend_ff  <= nxt_pend;
            comb_ff  <= comb;
        end
    end

    // apb answer: one access cycle after every setup
    always @(posedge mclk) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setupPh;
            pslverr <= setupPh & ~rdOk;
            if (rdEn) begin
                prdata <= rdMux;
            end
        end
    end

    // pad and request outputs
    always @(posedge mclk) begin
        if (rst) begin
            pinOut   <= {PINS{1'b0}};
            pinOe    <= {PINS{1'b0}};
            pullUpEn <= {PINS{1'b0}};
            altInVal <= {PINS{1'b0}};
            irqReq   <= {VECS{1'b0}};
            wakeUp   <= 1'b0;
        end else begin
            pinOut   <= nxt_pinOut;
            pinOe    <= nxt_pinOe;
            pullUpEn <= nxt_pullUp;
            altInVal <= nxt_altIn;
            // wait and halt do not touch pin state; they only enable wakeUp, the mask bit gates delivery
            irqReq <= pend_ff & {VECS{~cpu_ff[`GPE_CPU_MASK_BIT]}};
            wakeUp <= (|pend_ff) & (cpu_ff[`GPE_CPU_WAIT_BIT] |
                                    cpu_ff[`GPE_CPU_HALT_BIT]);
        end
    end
    // vector count is VECS, default seven; pins map via VEC_OF_PIN
endmodule // gpe_port

// ---- gpe_port_sva.sv ----
`timescale 1ns/1ps
module gpe_port_sva #(parameter PINS = 8, parameter VECS = 7) (
    input wire            mclk, rst, psel, penable, pwrite, pready, pslverr, wakeUp, // bus
    input wire [11:0]     paddr,  // address
    input wire [31:0]     pwdata, prdata, // data
    input wire [PINS-1:0] pinIn, pinOut, pinOe, pullUpEn, altOutEn, altOutVal, altInVal,
    input wire [VECS-1:0] vecFetch, irqReq // vectors
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_SETUP_READY: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    AST_PULL_IN: assert property ((pinOe & pullUpEn & ~altOutEn) == 0)
        else $error("pull-up on driven pin");
    AST_RST_QUIET: assert property (disable iff (1'b0) rst |=> pinOe == 0 && irqReq == 0)
        else $error("outputs active after reset");
    AST_OE_CAUSE: assert property ($changed(pinOe) |-> $past(penable && pwrite)
        || $past(penable && pwrite, 2) || $past(altOutEn) != $past(altOutEn, 3))
        else $error("pin drive changed without cause");
endmodule // gpe_port_sva
bind gpe_port gpe_port_sva #(.PINS(PINS), .VECS(VECS)) u_sva (.*);

// ---- gpe_regs.vh ----
`ifndef GPE_REGS_VH
`define GPE_REGS_VH
// register byte addresses on the APB
`define GPE_ADDR_LATCH   12'h000
`define GPE_ADDR_DIR     12'h004
`define GPE_ADDR_PAD     12'h008
`define GPE_ADDR_SENSE   12'h00C
`define GPE_ADDR_STATUS  12'h010
`define GPE_ADDR_CPU     12'h014
`define GPE_ADDR_ALTEN   12'h018
// reset value of the latch, direction, pad and alternate-enable registers
`define GPE_RST_BYTE     8'h00
// reset value of the cpu control register: global mask set
`define GPE_CPU_RST      3'h1
// sensitivity codes
`define GPE_SENS_FALLLOW 2'h0
`define GPE_SENS_RISE    2'h1
`define GPE_SENS_FALL    2'h2
`define GPE_SENS_BOTH    2'h3
// cpu control register fields
`define GPE_CPU_MASK_BIT 0
`define GPE_CPU_WAIT_BIT 1
`define GPE_CPU_HALT_BIT 2
`endif

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "gpe_regs.vh"
module tb_top;
    logic        mclk, rst, psel, penable, pwrite, pready, pslverr, wakeUp, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  pinIn, pinOut, pinOe, pullUpEn, altOutEn, altOutVal, altInVal, extEn, extVal;
    logic [7:0]  lat, pad;
    logic [6:0]  vecFetch, irqReq;
    integer      errors = 0, n_compared = 0, i;
    gpe_port uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
        .altOutEn(altOutEn), .altOutVal(altOutVal), .altInVal(altInVal),
        .vecFetch(vecFetch), .irqReq(irqReq), .wakeUp(wakeUp));
    gpe_pin_model u_pins (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
        .extEn(extEn), .extVal(extVal), .pinIn(pinIn));
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    task finish_test;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge mclk) penable <= 1;
        // waits for ready with no timeout; only the watchdog ends it if ready never comes
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(q, exp);
    endtask
    function logic [7:0] exp_oe(input logic [7:0] p, input logic [7:0] l);
        return p | ~l; // open-drain drives only a low
    endfunction
    initial begin
        {psel, penable, pwrite, paddr, pwdata, altOutEn, altOutVal, vecFetch, extEn, extVal} = 0;
        rst = 1;
        void'($urandom(57));
        repeat (10) @(posedge mclk);
        rst <= 0;
        rd(`GPE_ADDR_DIR, 0);
        rd(`GPE_ADDR_PAD, 0);
        for (i = 0; i < 4; i++) begin
            lat = $urandom;
            pad = $urandom;
            apb(1, `GPE_ADDR_DIR, 32'hFF);
            apb(1, `GPE_ADDR_PAD, pad);
            apb(1, `GPE_ADDR_LATCH, lat);
            repeat (3) @(posedge mclk);
            chk(pinOe, exp_oe(pad, lat));
            chk(pinOut & pinOe, lat & pinOe);
            chk(altInVal, lat);
            rd(`GPE_ADDR_LATCH, lat);
        end
        extEn <= 8'hFF;
        extVal <= $urandom;
        apb(1, `GPE_ADDR_DIR, 0);
        apb(1, `GPE_ADDR_LATCH, ~lat);
        repeat (4) @(posedge mclk);
        chk(pinOe, 0);
        chk(pullUpEn, pad);
        rd(`GPE_ADDR_LATCH, extVal);
        apb(1, `GPE_ADDR_ALTEN, 1);
        {altOutEn, altOutVal} <= 16'h0101;
        repeat (3) @(posedge mclk);
        chk(pinOe[0] & pinOut[0], 1);
        rd(`GPE_ADDR_LATCH, {extVal[7:1], 1'b1});
        {altOutEn, extVal} <= 16'h0000;
        apb(1, `GPE_ADDR_ALTEN, 0);
        for (i = 0; i < 4; i++) begin
            apb(1, `GPE_ADDR_SENSE, i);
            rd(`GPE_ADDR_SENSE, i);
        end
        apb(1, `GPE_ADDR_PAD, 1);
        apb(1, `GPE_ADDR_SENSE, `GPE_SENS_RISE);
        apb(1, `GPE_ADDR_CPU, 0);
        chk(irqReq, 0);
        extVal <= 1;
        repeat (4) @(posedge mclk);
        chk(irqReq, 1);
        vecFetch <= 1;
        @(posedge mclk) vecFetch <= 0;
        repeat (3) @(posedge mclk);
        chk(irqReq, 0);
        extVal <= 0;
        repeat (4) @(posedge mclk) extVal <= 1;
        repeat (4) @(posedge mclk);
        apb(1, `GPE_ADDR_CPU, 2);
        repeat (2) @(posedge mclk);
        chk(wakeUp, 1);
        apb(1, `GPE_ADDR_SENSE, `GPE_SENS_FALL);
        repeat (2) @(posedge mclk);
        chk(irqReq, 0);
        extVal <= 0;
        repeat (4) @(posedge mclk);
        chk(irqReq, 1);
        apb(1, `GPE_ADDR_CPU, 1);
        repeat (2) @(posedge mclk);
        chk(irqReq, 0);
        rd(`GPE_ADDR_STATUS, 1);
        apb(1, `GPE_ADDR_PAD, 3);
        apb(1, `GPE_ADDR_SENSE, `GPE_SENS_RISE);
        extVal <= 1;
        repeat (3) @(posedge mclk);
        rd(`GPE_ADDR_STATUS, 0);
        extVal <= 3;
        repeat (3) @(posedge mclk);
        rd(`GPE_ADDR_STATUS, 1);
        apb(0, 12'h01C, 0);
        chk(e, 1);
        chk(q, 0);
        finish_test;
    end
    initial begin
        #(25 * 20000);
        errors++;
        finish_test;
    end
endmodule // tb_top
